/* File: pkg/match_timer_pkg.sv */
// Constants for the 16-bit match timer: register offsets, field positions,
// reset values, clock-source codes and prescaler tap exponents.
// Assumes an 8-bit register port and one system clock acting as high_freq_clock.
package match_timer_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MATCH_LOW = 8'h04;
  localparam logic [7:0] OFF_MATCH_HIGH = 8'h08;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h0C;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CLEAR = 8'h18;
  localparam logic [7:0] OFF_ENABLE = 8'h1C;

  // Control register fields
  localparam int CTL_MODE_BIT = 0;
  localparam int CTL_SRC_LSB = 2;
  localparam int CTL_RUN_BIT = 5;
  localparam int CTL_TAP_BIT = 6;

  // Status, clear and enable share one layout
  localparam int STAT_MATCH_BIT = 0;

  // Values after reset
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [15:0] MATCH_RESET = 16'hFFFF;

  // Coarse compare keeps only the upper five bits
  localparam int COARSE_LSB = 11;

  // Source clock select codes
  localparam logic [2:0] SRC_TAP_SLOWEST = 3'h0;
  localparam logic [2:0] SRC_TAP_SLOW = 3'h1;
  localparam logic [2:0] SRC_TAP_FAST = 3'h2;
  localparam logic [2:0] SRC_TAP_FASTEST = 3'h3;
  localparam logic [2:0] SRC_FC_DIRECT = 3'h4;
  localparam logic [2:0] SRC_FS_DIRECT = 3'h5;
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;

  // Prescaler tap exponents
  localparam int FC_EXP_SLOWEST = 23;
  localparam int FC_EXP_SLOW = 13;
  localparam int FC_EXP_FAST = 8;
  localparam int FC_EXP_FASTEST = 3;
  localparam int FS_EXP_SLOWEST = 15;
  localparam int FS_EXP_SLOW = 5;
endpackage : match_timer_pkg

/* File: pkg/tick_if.sv */
// Link between the timer core and its prescaler: source choice in, tick out.
// Assumes both ends run on clk_sys.
interface tick_if;
  logic [2:0] src_sel;
  logic tap_sel;
  logic slow_any;
  logic tick;

  modport prescaler (input src_sel, input tap_sel, input slow_any, output tick);
  modport timer (output src_sel, output tap_sel, output slow_any, input tick);
endinterface : tick_if

/* File: rtl/tap_prescaler.sv */
// Prescaler: divides clk_sys (high_freq_clock) and the low_freq_clock pin
// into taps and issues one-cycle ticks of the selected internal source.
// Assumes low_freq_clock is far slower than clk_sys.
module tap_prescaler
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Low-frequency oscillator pin
  input wire logic low_freq_clock,
  // Link to timer core
  tick_if.prescaler link
);
  typedef struct packed {
    logic [22:0] fc_div;
    logic fs_s1;
    logic fs_s2;
    logic fs_d;
    logic [14:0] fs_div;
    logic tick;
  } presc_state_t;

  presc_state_t s;
  presc_state_t next_s;

  // True when the low n bits of a divider are all ones
  function automatic logic tap_hit(input logic [22:0] d, input int n);
    logic [22:0] mask;
    mask = 23'((64'(1) << n) - 64'(1));
    return (d & mask) == mask;
  endfunction : tap_hit

  // Divider stepping and source selection
  always_comb
  begin
    logic fs_edge;
    logic slow_col;
    logic [22:0] fs_wide;
    fs_edge = s.fs_s2 & ~s.fs_d;
    slow_col = link.slow_any | link.tap_sel;
    fs_wide = {8'h00, s.fs_div};
    next_s = s;
    next_s.fs_s1 = low_freq_clock;
    next_s.fs_s2 = s.fs_s1;
    next_s.fs_d = s.fs_s2;
    next_s.fc_div = s.fc_div + 23'h000001;
    if (fs_edge)
      next_s.fs_div = s.fs_div + 15'h0001;
    // Fast taps do not exist while only the slow oscillator runs
    case (link.src_sel)
      match_timer_pkg::SRC_TAP_SLOWEST:
        next_s.tick = slow_col ?
          (fs_edge & tap_hit(fs_wide, match_timer_pkg::FS_EXP_SLOWEST)) :
          tap_hit(s.fc_div, match_timer_pkg::FC_EXP_SLOWEST);
      match_timer_pkg::SRC_TAP_SLOW:
        next_s.tick = slow_col ?
          (fs_edge & tap_hit(fs_wide, match_timer_pkg::FS_EXP_SLOW)) :
          tap_hit(s.fc_div, match_timer_pkg::FC_EXP_SLOW);
      match_timer_pkg::SRC_TAP_FAST:
        next_s.tick = ~link.slow_any & tap_hit(s.fc_div, match_timer_pkg::FC_EXP_FAST);
      match_timer_pkg::SRC_TAP_FASTEST:
        next_s.tick = ~link.slow_any & tap_hit(s.fc_div, match_timer_pkg::FC_EXP_FASTEST);
      match_timer_pkg::SRC_FC_DIRECT:
        next_s.tick = link.slow_any;
      match_timer_pkg::SRC_FS_DIRECT:
        next_s.tick = ~link.slow_any & fs_edge;
      default:
        next_s.tick = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign link.tick = s.tick;
endmodule : tap_prescaler

/* File: rtl/match_timer.sv */
// 16-bit match timer core: register port, mode logic, match interrupt.
// Assumes the power manager drives its mode inputs on clk_sys.
module match_timer
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic count_input_pin,
  input wire logic low_freq_clock,
  // Power state
  input wire logic slow_mode_one,
  input wire logic slow_mode_two,
  input wire logic stop_enter,
  // Interrupt
  output logic match_irq
);
  typedef struct packed {
    logic mode_win;
    logic [2:0] src;
    logic run;
    logic tap;
    logic [15:0] match;
    logic [7:0] stage;
    logic pend;
    logic [15:0] count;
    logic stat;
    logic en;
    logic [7:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;
  tick_if link ();

  // Equality test, optionally on the upper five bits only
  function automatic logic match_hit(input logic [15:0] cnt, input logic [15:0] val,
                                     input logic coarse);
    if (coarse)
      return cnt[15:match_timer_pkg::COARSE_LSB] == val[15:match_timer_pkg::COARSE_LSB];
    return cnt == val;
  endfunction : match_hit

  // Source selection towards the prescaler
  assign link.src_sel = s.src;
  assign link.tap_sel = s.tap;
  assign link.slow_any = slow_mode_one | slow_mode_two;

  tap_prescaler u_presc
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .low_freq_clock(low_freq_clock),
    .link(link)
  );

  logic wr_ctl;
  logic wr_low;
  logic wr_high;
  logic wr_clr;
  logic wr_en;
  logic ext_src;
  logic event_mode;
  logic coarse;
  logic pin_rise;
  logic pin_fall;
  logic step;
  logic hit;
  logic match_event;

  // Address decode and pin edges; the edge logic compares the second flop with its delayed copy pin_d
  assign wr_ctl = reg_wr && reg_addr == match_timer_pkg::OFF_CONTROL;
  assign wr_low = reg_wr && reg_addr == match_timer_pkg::OFF_MATCH_LOW;
  assign wr_high = reg_wr && reg_addr == match_timer_pkg::OFF_MATCH_HIGH;
  assign wr_clr = reg_wr && reg_addr == match_timer_pkg::OFF_CLEAR;
  assign wr_en = reg_wr && reg_addr == match_timer_pkg::OFF_ENABLE;
  assign ext_src = s.src == match_timer_pkg::SRC_EXTERNAL;
  assign event_mode = !s.mode_win && ext_src;
  assign pin_rise = s.pin_s2 && !s.pin_d;
  assign pin_fall = !s.pin_s2 && s.pin_d;
  // Upper-five-bit compare for the direct fc source in slow modes (warm-up)
  assign coarse = !s.mode_win && s.src == match_timer_pkg::SRC_FC_DIRECT &&
                  link.slow_any;
  assign hit = match_hit(s.count, s.match, coarse);

  // Internal tick counts in timer mode, and in window mode only with the gate high
  always_comb
  begin
    if (s.mode_win)
      step = link.tick && !ext_src && s.pin_s2;
    else
      step = link.tick && !ext_src;
  end

  // Match event: on a tick for internal sources, on a falling pin edge for events
  assign match_event = s.run && (event_mode ? (pin_fall && hit) : (step && hit));

  // Next-state logic for registers, counter and flags
  always_comb
  begin
    next_s = s;
    next_s.pin_s1 = count_input_pin;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_d = s.pin_s2;
    if (wr_ctl)
    begin
      next_s.mode_win = reg_wdata[match_timer_pkg::CTL_MODE_BIT];
      next_s.src = reg_wdata[match_timer_pkg::CTL_SRC_LSB +: 3];
      next_s.run = reg_wdata[match_timer_pkg::CTL_RUN_BIT];
      next_s.tap = reg_wdata[match_timer_pkg::CTL_TAP_BIT];
    end
    // Stop entry wins over a software start in the same cycle
    if (stop_enter)
      next_s.run = 1'b0;
    // Low byte is only staged; old value keeps comparing
    if (wr_low)
    begin
      next_s.stage = reg_wdata;
      next_s.pend = 1'b1;
    end
    if (wr_high)
    begin
      next_s.pend = 1'b0;
      if (s.pend)
        next_s.match = {reg_wdata, s.stage};
      else if (coarse)
        next_s.match[15:8] = reg_wdata;
    end
    if (!s.run)
      next_s.count = 16'h0000;
    else if (match_event)
      next_s.count = 16'h0000;
    else if (event_mode ? pin_rise : step)
      next_s.count = s.count + 16'h0001;
    // Set wins over a clear in the same cycle
    if (wr_clr && reg_wdata[match_timer_pkg::STAT_MATCH_BIT])
      next_s.stat = 1'b0;
    if (match_event)
      next_s.stat = 1'b1;
    if (wr_en)
      next_s.en = reg_wdata[match_timer_pkg::STAT_MATCH_BIT];
    // Read data stands only in the cycle after the strobe
    next_s.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        match_timer_pkg::OFF_CONTROL:
          next_s.rdata = {1'b0, s.tap, s.run, s.src, 1'b0, s.mode_win};
        match_timer_pkg::OFF_MATCH_LOW:
          next_s.rdata = s.match[7:0];
        match_timer_pkg::OFF_MATCH_HIGH:
          next_s.rdata = s.match[15:8];
        match_timer_pkg::OFF_COUNT_LOW:
          next_s.rdata = s.count[7:0];
        match_timer_pkg::OFF_COUNT_HIGH:
          next_s.rdata = s.count[15:8];
        match_timer_pkg::OFF_STATUS:
          next_s.rdata = {7'h00, s.stat};
        match_timer_pkg::OFF_ENABLE:
          next_s.rdata = {7'h00, s.en};
        default:
          next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.src <= match_timer_pkg::SRC_RESET;
      s.match <= match_timer_pkg::MATCH_RESET;
    end
    else
      s <= next_s;
  end

  assign reg_rdata = s.rdata;
  // Level interrupt while an enabled status bit is set
  assign match_irq = s.stat && s.en;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Low write followed by a high write commits both halves together
  sequence seq_low_then_high;
    wr_low ##1 (!wr_low && !stop_enter) ##1 wr_high;
  endsequence

  sequence seq_evt_rise_fall;
    event_mode && s.run && pin_rise ##[2:40] pin_fall;
  endsequence

  a_match_commit: assert property (seq_low_then_high |=> s.match[7:0] == s.stage)
    else $error("match halves not committed together");

  a_low_staged: assert property (wr_low && !wr_high |=> $stable(s.match))
    else $error("low byte changed live match");

  a_stop_halts: assert property (stop_enter |=> !s.run ##1 s.count == 16'h0000)
    else $error("stop entry did not halt counter");

  a_timer_wrap: assert property (
    !event_mode && s.run && step && hit && !stop_enter && !wr_ctl
    |=> s.count == 16'h0000 && s.stat)
    else $error("timer match did not clear and flag");

  a_event_step: assert property (
    event_mode && s.run && pin_rise && !wr_ctl && !stop_enter
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("rising edge not counted");

  a_event_fall: assert property (
    seq_evt_rise_fall ##0 (hit && !wr_ctl && !stop_enter) |=> s.count == 16'h0000 && s.stat)
    else $error("event match missed at falling edge");

  a_window_hold: assert property (
    s.mode_win && !s.pin_s2 && s.run && !wr_ctl && !stop_enter |=> $stable(s.count))
    else $error("window counted with gate low");

  a_coarse_cmp: assert property (
    coarse && s.run && step && s.count[15:11] == s.match[15:11] && !stop_enter && !wr_ctl
    |=> s.count == 16'h0000)
    else $error("coarse compare did not fire");

  a_irq_gate: assert property (match_event && s.en && !wr_en |=> match_irq)
    else $error("enabled match did not raise interrupt");

  a_read_once: assert property (reg_rd && reg_addr == match_timer_pkg::OFF_STATUS
    |=> reg_rdata == {7'h00, $past(s.stat)} ##1 (reg_rd || reg_rdata == 8'h00))
    else $error("status read data wrong");
endmodule : match_timer

/* File: verif/pin_source.sv */
// Behavioural source of the external count/gate pin.
// Assumes it shares clk_sys with the timer; the pin is push-pull, never released.
module pin_source
(
  // Clock
  input wire logic clk_sys,
  // Pin level
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pin = 1'b0;

  // Each level lasts at least four cycles, so the synchroniser sees every edge
  task automatic set_level(input logic lvl, input int hold);
    @(posedge clk_sys);
    pin <= lvl;
    repeat ((hold < 4) ? 3 : hold - 1) @(posedge clk_sys);
    #1;
  endtask : set_level

  // Whole pulses, high then low
  task automatic pulse(input int n);
    repeat (n)
    begin
      set_level(1'b1, 6);
      set_level(1'b0, 6);
    end
  endtask : pulse
endmodule : pin_source

/* File: verif/match_timer_tb.sv */
// Self-checking bench: register port, the three modes, coarse compare, stop.
// Assumes pin_source drives the count pin and everything runs on clk_sys.
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      $display("mismatch %s exp %h got %h", nm, ex, got); \
      fail_count++; \
    end \
  end

module match_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, reg_wr, reg_rd, count_input_pin, low_freq_clock;
  logic slow_mode_one, slow_mode_two, stop_enter, match_irq, irq_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] lf_div;
  int fail_count, check_count, cyc, rise_at, gap;

  match_timer u_match_timer (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_input_pin(count_input_pin), .low_freq_clock(low_freq_clock),
    .slow_mode_one(slow_mode_one), .slow_mode_two(slow_mode_two),
    .stop_enter(stop_enter), .match_irq(match_irq));
  pin_source u_pin_source (.clk_sys(clk_sys), .pin(count_input_pin));

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Slow oscillator stand-in; interval between interrupt rises, for period checks
  always @(posedge clk_sys)
  begin
    lf_div <= lf_div + 6'h01;
    low_freq_clock <= lf_div[5];
    cyc <= cyc + 1;
    irq_q <= match_irq;
    if (match_irq === 1'b1 && irq_q !== 1'b1)
    begin
      gap <= cyc - rise_at;
      rise_at <= cyc;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (match_irq !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_irq

  function automatic logic [7:0] ctl(input logic [2:0] src, input logic mode, input logic run);
    ctl = 8'h00;
    ctl[match_timer_pkg::CTL_SRC_LSB +: 3] = src;
    ctl[match_timer_pkg::CTL_MODE_BIT] = mode;
    ctl[match_timer_pkg::CTL_RUN_BIT] = run;
  endfunction : ctl

  // Whole map after reset, including an ignored write to an unmapped place
  task automatic reset_regs();
    logic [7:0] a;
    logic [7:0] d;
    wr(8'h20, 8'h55);
    for (int i = 0; i < 9; i++)
    begin
      a = 8'(i * 4);
      rd(a, d);
      `CHK("reset map", (a == 8'h04 || a == 8'h08) ? 8'hFF : 8'h00, d);
    end
  endtask : reset_regs

  task automatic match_pairing();
    logic [7:0] d;
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h12);
    rd(match_timer_pkg::OFF_MATCH_HIGH, d);
    `CHK("lone high", 8'hFF, d);
    wr(match_timer_pkg::OFF_MATCH_LOW, 8'h34);
    rd(match_timer_pkg::OFF_MATCH_LOW, d);
    `CHK("pending low", 8'hFF, d);
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h56);
    rd(match_timer_pkg::OFF_MATCH_LOW, d);
    `CHK("commit low", 8'h34, d);
    rd(match_timer_pkg::OFF_MATCH_HIGH, d);
    `CHK("commit high", 8'h56, d);
  endtask : match_pairing

  // Masked match, then period of M+1 ticks between two interrupts
  task automatic timer_mode();
    logic [7:0] d;
    int n;
    wr(match_timer_pkg::OFF_MATCH_LOW, 8'h03);
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h00);
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_TAP_FASTEST, 1'b0, 1'b1));
    repeat (48) @(posedge clk_sys);
    rd(match_timer_pkg::OFF_STATUS, d);
    `CHK("status", 8'h01, d);
    `CHK("irq masked", 1'b0, match_irq);
    wr(match_timer_pkg::OFF_ENABLE, 8'h01);
    `CHK("irq enabled", 1'b1, match_irq);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    wait_irq(100, n);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    wait_irq(100, n);
    @(posedge clk_sys);
    #1;
    `CHK("period", 4 * (1 << match_timer_pkg::FC_EXP_FASTEST), gap);
    wr(match_timer_pkg::OFF_CONTROL, 8'h00);
    // Direct slow-oscillator source: four rises of a 64-cycle stand-in clock
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_FS_DIRECT, 1'b0, 1'b1));
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    wait_irq(400, n);
    `CHK("fs source", 1'b1, n >= 180 && n <= 270);
    wr(match_timer_pkg::OFF_CONTROL, 8'h00);
  endtask : timer_mode

  task automatic event_mode();
    logic [7:0] d;
    wr(match_timer_pkg::OFF_MATCH_LOW, 8'h02);
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h00);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_EXTERNAL, 1'b0, 1'b1));
    u_pin_source.pulse(1);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("event count", 8'h01, d);
    u_pin_source.set_level(1'b1, 6);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("count at match", 8'h02, d);
    `CHK("irq before fall", 1'b0, match_irq);
    u_pin_source.set_level(1'b0, 8);
    `CHK("irq at fall", 1'b1, match_irq);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("cleared", 8'h00, d);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    u_pin_source.pulse(1);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("resumed", 8'h01, d);
    wr(match_timer_pkg::OFF_CONTROL, 8'h00);
  endtask : event_mode

  task automatic window_mode();
    logic [7:0] d;
    logic [7:0] c1;
    int n;
    wr(match_timer_pkg::OFF_MATCH_LOW, 8'h03);
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h00);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_TAP_FASTEST, 1'b1, 1'b1));
    repeat (40) @(posedge clk_sys);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("gate low", 8'h00, d);
    u_pin_source.set_level(1'b1, 20);
    u_pin_source.set_level(1'b0, 4);
    rd(match_timer_pkg::OFF_COUNT_LOW, c1);
    `CHK("gated ticks", 1'b1, c1 >= 8'h02 && c1 <= 8'h03);
    repeat (40) @(posedge clk_sys);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("held", c1, d);
    u_pin_source.set_level(1'b1, 4);
    wait_irq(100, n);
    `CHK("window match", 1'b1, match_irq);
    u_pin_source.set_level(1'b0, 4);
    wr(match_timer_pkg::OFF_CONTROL, 8'h00);
  endtask : window_mode

  // Lone high-byte write and five-bit compare, then stop entry
  task automatic coarse_stop();
    logic [7:0] d;
    int n;
    @(posedge clk_sys);
    slow_mode_two <= 1'b1;
    wr(match_timer_pkg::OFF_MATCH_LOW, 8'hFF);
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h00);
    wr(match_timer_pkg::OFF_CLEAR, 8'h01);
    // The lone high write only counts once the coarse source is chosen, timer stopped
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_FC_DIRECT, 1'b0, 1'b0));
    wr(match_timer_pkg::OFF_MATCH_HIGH, 8'h10);
    rd(match_timer_pkg::OFF_MATCH_HIGH, d);
    `CHK("high only", 8'h10, d);
    wr(match_timer_pkg::OFF_CONTROL, ctl(match_timer_pkg::SRC_FC_DIRECT, 1'b0, 1'b1));
    wait_irq(5000, n);
    `CHK("coarse match", 1'b1, n >= 4090 && n <= 4110);
    @(posedge clk_sys);
    stop_enter <= 1'b1;
    @(posedge clk_sys);
    stop_enter <= 1'b0;
    rd(match_timer_pkg::OFF_CONTROL, d);
    `CHK("run cleared", ctl(match_timer_pkg::SRC_FC_DIRECT, 1'b0, 1'b0), d);
    rd(match_timer_pkg::OFF_COUNT_LOW, d);
    `CHK("halted", 8'h00, d);
    slow_mode_two <= 1'b0;
  endtask : coarse_stop

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the longest scenario
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end

  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow_mode_one = 1'b0;
    slow_mode_two = 1'b0;
    stop_enter = 1'b0;
    low_freq_clock = 1'b0;
    lf_div = 6'h00;
    cyc = 0;
    rise_at = 0;
    gap = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    reset_regs();
    match_pairing();
    timer_mode();
    event_mode();
    window_mode();
    coarse_stop();
    give_verdict();
  end
endmodule : match_timer_tb
